// [logic/fic_pkg.sv]
// Package for the floating-point issue control block: operation classes,
// timing counts and pipe figures.
// Assumes a single core clock at 100 MHz.
package fic_pkg;
   // Operation class carried with each candidate instruction
   typedef enum logic [2:0] {
      FIC_OP_NONE,
      FIC_OP_SIMPLE,
      FIC_OP_MUL,
      FIC_OP_DIVSQRT,
      FIC_OP_LOAD,
      FIC_OP_STORE,
      FIC_OP_SYSREG
   } fic_op_t;

   // First execute stage occupancy
   localparam logic [3:0] FIC_E1_DMUL_CYC = 4'h2;
   localparam logic [3:0] FIC_E1_SCALAR_CYC = 4'h1;
   // Divide pipe busy time
   localparam logic [4:0] FIC_DIV_BUSY_S = 5'h0D;
   localparam logic [4:0] FIC_DIV_BUSY_D = 5'h1B;
   // Throughput and latency figures
   localparam logic [5:0] FIC_LAT_SIMPLE = 6'h04;
   localparam logic [5:0] FIC_LAT_MUL_S = 6'h04;
   localparam logic [5:0] FIC_LAT_MUL_D = 6'h05;
   localparam logic [5:0] FIC_THR_MUL_D = 6'h02;
   localparam logic [5:0] FIC_THR_DIV_S = 6'h0E;
   localparam logic [5:0] FIC_LAT_DIV_S = 6'h11;
   localparam logic [5:0] FIC_THR_DIV_D = 6'h1C;
   localparam logic [5:0] FIC_LAT_DIV_D = 6'h1F;
   localparam logic [5:0] FIC_LAT_LOAD_EXTRA = 6'h02;
   localparam logic [5:0] FIC_LAT_STORE_EXTRA = 6'h01;
   localparam logic [5:0] FIC_LAT_SYSREG = 6'h02;
   // Forwarding saving
   localparam logic [5:0] FIC_FWD_SAVE = 6'h01;
   // Single values moved per load/store cycle
   localparam logic [4:0] FIC_LS_SINGLES_PER_CYC = 5'h02;
   // Register bank 0 limit for single registers (s0..s7)
   localparam logic [4:0] FIC_BANK0_LIMIT = 5'h08;
   // Vector length field width and register count
   localparam int FIC_LEN_W = 3;
   localparam int FIC_NREG = 32;
endpackage : fic_pkg

// [logic/fic_divide_tracker.sv]
// Divide/square-root pipe occupancy counter.
// Assumes the issue logic pulses start only when the pipe is free.
`timescale 1ns/10ps
`default_nettype none
module fic_divide_tracker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Start of a divide or square root
   input wire logic start,
   input wire logic dbl,
   // Busy state
   output logic busy
);
   logic [4:0] count_reg;

   // Holds the pipe for 13 or 27 cycles [RQ5]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 5'h00;
      end else if (ce) begin
         if (start) begin
            count_reg <= dbl ? fic_pkg::FIC_DIV_BUSY_D
                             : fic_pkg::FIC_DIV_BUSY_S;
         end else if (count_reg != 5'h00) begin
            count_reg <= count_reg - 5'h01;
         end
      end
   end

   assign busy = (count_reg != 5'h00);
endmodule : fic_divide_tracker
`default_nettype wire

// [logic/fic_scoreboard.sv]
// Register lock scoreboard for 32 single registers.
// Assumes lock and release masks come from the issue logic.
`timescale 1ns/10ps
`default_nettype none
module fic_scoreboard (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // Lock requests and releases
   input wire logic [31:0] lock_mask,
   input wire logic [31:0] release_mask,
   // Query
   input wire logic [31:0] query_mask,
   output logic hazard
);
   logic [31:0] lock_reg;

   // Release then lock; a new lock wins over a release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_reg <= 32'h0000_0000;
      end else if (ce) begin
         lock_reg <= (lock_reg & ~release_mask) | lock_mask;
      end
   end

   // Any locked register queried stalls, destination writes included [RQ23]
   assign hazard = |(lock_reg & query_mask);
endmodule : fic_scoreboard
`default_nettype wire

// [logic/fic_issue_control.sv]
// Issue and resource-hazard control for a three-pipe floating-point
// coprocessor. Assumes the core holds a candidate steady while stalled.
`timescale 1ns/10ps
`default_nettype none

// Function
// RQ1 - Load/store pipe never stalls for arithmetic, nor arithmetic for it.
// RQ2 - First execute stage is shared; a vector op stalls later arithmetic.
// RQ3 - Transfer waits for earlier transfer; core may stall transfers.
// RQ4 - Double multiply holds first execute stage two cycles.
// RQ5 - Divide pipe busy 13 single or 27 double cycles.
// RQ6 - Load/store starts with no hazard, no core stall, no multiple busy.
// RQ7 - Arithmetic issues when no hazard, stage free, no vector running.
// RQ8 - Divide issues when no hazard, divide pipe free, no vector running.
// RQ9 - The three pipes run concurrently without blocking each other.
// RQ10 - Scalar divide uses first stage one cycle; vector holds all iterations.
// RQ11 - Vector op holds first stage one cycle per iteration.
// RQ12 - Destination in bank 0 forces scalar execution.
// RQ13 - Single load after unfinished multiple stalls until it completes.
// RQ14 - Simple ops have throughput 1, latency 4.
// RQ15 - Multiply ops: 1/4 single, 2/5 double.
// RQ16 - Divide ops: 14/17 single, 28/31 double.
// RQ17 - Single transfers move two single values per cycle.
// RQ18 - Multiple takes ceil(N/2) or N cycles; latency plus two or one.
// RQ19 - Each multiple word is usable once transferred.
// RQ20 - Matching precision forwarding saves one latency cycle.
// RQ21 - System register transfers serialize.
// RQ22 - Sources released in first execute cycle, destination near end.
// RQ23 - Reads of locked registers stall until release.
// RQ24 - Stall shown every cycle while issue is not allowed.
module fic_issue_control (
   // Clock, enable and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // Candidate instruction from the core
   input wire logic OP_VALID,
   input wire fic_pkg::fic_op_t OP_CLASS,
   input wire logic OP_DOUBLE,
   input wire logic OP_MULTIPLE,
   input wire logic [4:0] OP_WORD_COUNT,
   input wire logic [4:0] OP_DEST,
   input wire logic [31:0] OP_SRC_MASK,
   input wire logic OP_SRC_DOUBLE,
   input wire logic OP_PROD_DOUBLE,
   input wire logic [2:0] VECTOR_LENGTH_FIELD,
   // Core data stall for transfers
   input wire logic CORE_DATA_STALL,
   // Issue answer
   output logic ISSUE,
   output logic STALL,
   output logic CORE_HOLD,
   // Timing of the issued op
   output logic [5:0] ISSUE_LATENCY,
   output logic [5:0] ISSUE_THROUGHPUT,
   // Pipe state
   output logic LS_BUSY,
   output logic E1_BUSY,
   output logic DIV_BUSY
);
   typedef enum logic [1:0] {
      FIC_LS_IDLE,
      FIC_LS_MULTI,
      FIC_LS_SINGLE
   } fic_ls_state_t;

   fic_ls_state_t ls_state_reg;
   logic [4:0] ls_cnt_reg;
   logic [4:0] ls_base_reg;
   logic ls_dbl_reg;
   logic [3:0] e1_cnt_reg;
   logic e1_vec_reg;
   logic [5:0] issue_lat_reg;
   logic [5:0] issue_thr_reg;
   logic [31:0] dest_pend_reg [0:3];
   logic [31:0] lock_mask;
   logic [31:0] release_mask;
   logic [31:0] query_mask;
   logic data_hazard;
   logic div_busy;
   logic is_ls;
   logic is_arith;
   logic is_div;
   logic is_vec;
   logic [3:0] iters;
   logic ls_ok;
   logic ar_ok;
   logic dv_ok;
   logic sys_ok;
   logic can_issue;
   logic [4:0] ls_cycles;
   logic [31:0] dest_mask;
   logic [5:0] base_lat;
   logic [4:0] ls_chunk;

   // Ceiling of half the word count
   function automatic logic [4:0] half_up(input logic [4:0] n);
      half_up = n[4:1] + {4'h0, n[0]};
   endfunction : half_up

   // Mask of consecutive registers from a base
   function automatic logic [31:0] reg_span(input logic [4:0] base,
                                             input logic [4:0] cnt);
      logic [31:0] m;
      m = 32'h0000_0000;
      for (int i = 0; i < fic_pkg::FIC_NREG; i++) begin
         if (5'(i) >= base && ({1'b0, 5'(i)} < {1'b0, base} + {1'b0, cnt}))
         begin
            m[i] = 1'b1;
         end
      end
      reg_span = m;
   endfunction : reg_span

   assign is_ls = (OP_CLASS == fic_pkg::FIC_OP_LOAD) ||
                  (OP_CLASS == fic_pkg::FIC_OP_STORE);
   assign is_div = (OP_CLASS == fic_pkg::FIC_OP_DIVSQRT);
   assign is_arith = (OP_CLASS == fic_pkg::FIC_OP_SIMPLE) ||
                     (OP_CLASS == fic_pkg::FIC_OP_MUL);
   // Bank 0 destination forces scalar [RQ12]
   assign is_vec = (VECTOR_LENGTH_FIELD != 3'h0) &&
                   (OP_DEST >= fic_pkg::FIC_BANK0_LIMIT);
   assign iters = is_vec ? {1'b0, VECTOR_LENGTH_FIELD} + 4'h1 : 4'h1;
   // Transfer cycle count; two singles per cycle [RQ17] [RQ18]
   assign ls_cycles = OP_DOUBLE ? OP_WORD_COUNT : half_up(OP_WORD_COUNT);
   assign dest_mask = is_ls ? reg_span(OP_DEST, OP_WORD_COUNT)
                            : reg_span(OP_DEST, {1'b0, iters});
   assign query_mask = OP_SRC_MASK | dest_mask;

   // Load/store gate independent of arithmetic state [RQ1] [RQ6] [RQ3]
   assign ls_ok = (ls_state_reg == FIC_LS_IDLE) && !CORE_DATA_STALL;
   // Arithmetic gate [RQ2] [RQ4] [RQ7] [RQ11]
   assign ar_ok = (e1_cnt_reg == 4'h0);
   // Divide gate [RQ8] [RQ10]
   assign dv_ok = !div_busy && !(e1_vec_reg && e1_cnt_reg != 4'h0);
   // System register moves wait for all pipes [RQ21]
   assign sys_ok = ls_state_reg == FIC_LS_IDLE && e1_cnt_reg == 4'h0 &&
                   !div_busy;
   always_comb begin
      can_issue = 1'b0;
      case (OP_CLASS)
         fic_pkg::FIC_OP_SIMPLE,
         fic_pkg::FIC_OP_MUL: can_issue = ar_ok;
         fic_pkg::FIC_OP_DIVSQRT: can_issue = dv_ok;
         fic_pkg::FIC_OP_LOAD,
         fic_pkg::FIC_OP_STORE: can_issue = ls_ok;
         fic_pkg::FIC_OP_SYSREG: can_issue = sys_ok;
         default: can_issue = 1'b0;
      endcase
   end
   // Each pipe gated by its own state and the data hazard; divide also waits on a vector in E1 [RQ9]
   assign ISSUE = OP_VALID && can_issue && !data_hazard;
   // Stall every cycle the candidate cannot go [RQ24]
   assign STALL = OP_VALID && !ISSUE;
   // Core held while a load or store waits on a multiple [RQ13]
   assign CORE_HOLD = STALL && is_ls && ls_state_reg == FIC_LS_MULTI;

   // Source locks taken at issue, released next cycle; dest near end [RQ22]
   assign lock_mask = ISSUE ? query_mask : 32'h0000_0000;
   assign ls_chunk = ls_dbl_reg ? 5'h01 : fic_pkg::FIC_LS_SINGLES_PER_CYC;
   always_comb begin
      release_mask = dest_pend_reg[0];
      if (ls_state_reg == FIC_LS_MULTI && !CORE_DATA_STALL) begin
         // Words freed as transferred; last cycle frees the tail [RQ19]
         release_mask = release_mask | reg_span(ls_base_reg,
                        (ls_cnt_reg == 5'h01) ? {ls_chunk[3:0], 1'b0}
                                              : ls_chunk);
      end
   end

   fic_scoreboard u_scoreboard (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .lock_mask(lock_mask),
      .release_mask(release_mask),
      .query_mask(query_mask),
      .hazard(data_hazard)
   );

   fic_divide_tracker u_divide (
      .clk(SYS_CLK),
      .rst_n(RESET_N),
      .ce(CLK_EN),
      .start(ISSUE && is_div),
      .dbl(OP_DOUBLE),
      .busy(div_busy)
   );

   // Release pipeline: every issued op frees sources and dest; a load multiple of more than one cycle frees only its sources here
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         for (int i = 0; i < 4; i++) begin
            dest_pend_reg[i] <= 32'h0000_0000;
         end
      end else if (CLK_EN) begin
         dest_pend_reg[0] <= dest_pend_reg[1];
         dest_pend_reg[1] <= dest_pend_reg[2];
         dest_pend_reg[2] <= dest_pend_reg[3];
         dest_pend_reg[3] <= 32'h0000_0000;
         if (ISSUE && !is_ls) begin
            dest_pend_reg[0] <= dest_pend_reg[1] | OP_SRC_MASK; // [RQ22]
            dest_pend_reg[3] <= dest_mask;
         end else if (ISSUE && OP_CLASS == fic_pkg::FIC_OP_STORE) begin
            dest_pend_reg[0] <= dest_pend_reg[1] | query_mask;
         end else if (ISSUE && (!OP_MULTIPLE || ls_cycles <= 5'h01)) begin
            dest_pend_reg[1] <= dest_pend_reg[2] | query_mask;
         end else if (ISSUE) begin
            // Multiple frees its sources at once, words as they move
            dest_pend_reg[0] <= dest_pend_reg[1] | OP_SRC_MASK;
         end
      end
   end

   // First execute stage occupancy [RQ2] [RQ4] [RQ10] [RQ11]
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         e1_cnt_reg <= 4'h0;
         e1_vec_reg <= 1'b0;
      end else if (CLK_EN) begin
         if (ISSUE && (is_arith || is_div)) begin
            e1_vec_reg <= is_vec;
            if (OP_CLASS == fic_pkg::FIC_OP_MUL && OP_DOUBLE) begin
               e1_cnt_reg <= 4'((iters * fic_pkg::FIC_E1_DMUL_CYC) - 4'h1);
            end else begin
               e1_cnt_reg <= 4'((iters * fic_pkg::FIC_E1_SCALAR_CYC) - 4'h1);
            end
         end else if (e1_cnt_reg != 4'h0) begin
            e1_cnt_reg <= e1_cnt_reg - 4'h1;
         end else begin
            e1_vec_reg <= 1'b0;
         end
      end
   end

   // Load/store multiple sequencer [RQ3] [RQ18] [RQ13]
   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         ls_state_reg <= FIC_LS_IDLE;
         ls_cnt_reg <= 5'h00;
         ls_base_reg <= 5'h00;
         ls_dbl_reg <= 1'b0;
      end else if (CLK_EN) begin
         case (ls_state_reg)
            FIC_LS_IDLE: begin
               if (ISSUE && is_ls && OP_MULTIPLE && ls_cycles > 5'h01) begin
                  ls_state_reg <= FIC_LS_MULTI;
                  ls_cnt_reg <= ls_cycles - 5'h01;
                  ls_base_reg <= OP_DEST;
                  ls_dbl_reg <= OP_DOUBLE;
               end
            end
            FIC_LS_MULTI: begin
               if (!CORE_DATA_STALL) begin
                  ls_base_reg <= ls_base_reg + (ls_dbl_reg ? 5'h01 :
                                 fic_pkg::FIC_LS_SINGLES_PER_CYC);
                  ls_cnt_reg <= ls_cnt_reg - 5'h01;
                  if (ls_cnt_reg == 5'h01) begin
                     ls_state_reg <= FIC_LS_IDLE;
                  end
               end
            end
            default: ls_state_reg <= FIC_LS_IDLE;
         endcase
      end
   end

   // Throughput and latency of the op being issued [RQ14] [RQ15] [RQ16]
   always_comb begin
      base_lat = fic_pkg::FIC_LAT_SIMPLE;
      case (OP_CLASS)
         fic_pkg::FIC_OP_MUL: base_lat = OP_DOUBLE ?
            fic_pkg::FIC_LAT_MUL_D : fic_pkg::FIC_LAT_MUL_S;
         fic_pkg::FIC_OP_DIVSQRT: base_lat = OP_DOUBLE ?
            fic_pkg::FIC_LAT_DIV_D : fic_pkg::FIC_LAT_DIV_S;
         fic_pkg::FIC_OP_LOAD: base_lat = {1'b0, ls_cycles} +
            fic_pkg::FIC_LAT_LOAD_EXTRA;
         fic_pkg::FIC_OP_STORE: base_lat = {1'b0, ls_cycles} +
            fic_pkg::FIC_LAT_STORE_EXTRA;
         fic_pkg::FIC_OP_SYSREG: base_lat = fic_pkg::FIC_LAT_SYSREG;
         default: base_lat = fic_pkg::FIC_LAT_SIMPLE;
      endcase
   end

   always_ff @(posedge SYS_CLK or negedge RESET_N) begin
      if (!RESET_N) begin
         issue_lat_reg <= 6'h00;
         issue_thr_reg <= 6'h00;
      end else if (CLK_EN && ISSUE) begin
         // Forwarding saves a cycle on matching precision [RQ20]
         issue_lat_reg <= (OP_PROD_DOUBLE == OP_SRC_DOUBLE) ?
                          base_lat - fic_pkg::FIC_FWD_SAVE : base_lat;
         case (OP_CLASS)
            fic_pkg::FIC_OP_MUL: issue_thr_reg <= OP_DOUBLE ?
               fic_pkg::FIC_THR_MUL_D : 6'h01;
            fic_pkg::FIC_OP_DIVSQRT: issue_thr_reg <= OP_DOUBLE ?
               fic_pkg::FIC_THR_DIV_D : fic_pkg::FIC_THR_DIV_S;
            fic_pkg::FIC_OP_LOAD,
            fic_pkg::FIC_OP_STORE: issue_thr_reg <= {1'b0, ls_cycles};
            default: issue_thr_reg <= 6'h01;
         endcase
      end
   end

   assign ISSUE_LATENCY = issue_lat_reg;
   assign ISSUE_THROUGHPUT = issue_thr_reg;
   assign LS_BUSY = (ls_state_reg != FIC_LS_IDLE);
   assign E1_BUSY = (e1_cnt_reg != 4'h0);
   assign DIV_BUSY = div_busy;
endmodule : fic_issue_control
`default_nettype wire

// [sim/fic_issue_control_chk.sv]
// Checker for the issue control block: refusals, occupancy and timing.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module fic_issue_control_chk (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic RESET_N,
   input wire logic CLK_EN,
   // Candidate
   input wire logic OP_VALID,
   input wire fic_pkg::fic_op_t OP_CLASS,
   input wire logic OP_DOUBLE,
   input wire logic [4:0] OP_DEST,
   input wire logic OP_SRC_DOUBLE,
   input wire logic OP_PROD_DOUBLE,
   input wire logic [2:0] VECTOR_LENGTH_FIELD,
   input wire logic CORE_DATA_STALL,
   // Answer and state
   input wire logic ISSUE,
   input wire logic STALL,
   input wire logic CORE_HOLD,
   input wire logic [5:0] ISSUE_LATENCY,
   input wire logic [5:0] ISSUE_THROUGHPUT,
   input wire logic LS_BUSY,
   input wire logic E1_BUSY,
   input wire logic DIV_BUSY
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESET_N || !CLK_EN);
   logic take, ls, ar, dv, vec;
   assign take = ISSUE && CLK_EN;
   assign ls = OP_CLASS inside {fic_pkg::FIC_OP_LOAD, fic_pkg::FIC_OP_STORE};
   assign ar = OP_CLASS inside {fic_pkg::FIC_OP_SIMPLE, fic_pkg::FIC_OP_MUL};
   assign dv = OP_CLASS == fic_pkg::FIC_OP_DIVSQRT;
   assign vec = VECTOR_LENGTH_FIELD != 3'h0 && OP_DEST >= 5'h08;
   sequence s_div13;
      DIV_BUSY [*8] ##1 DIV_BUSY [*5];
   endsequence
   sequence s_div27;
      DIV_BUSY [*8] ##1 DIV_BUSY [*8] ##1 DIV_BUSY [*8] ##1 DIV_BUSY [*3];
   endsequence
   sequence s_vec4;
      E1_BUSY [*3] ##1 !E1_BUSY;
   endsequence
   property p_stall;
      STALL == (OP_VALID && !ISSUE);
   endproperty
   property p_ls_core;
      OP_VALID && ls && CORE_DATA_STALL |-> !ISSUE;
   endproperty
   property p_ls_busy;
      OP_VALID && ls && LS_BUSY |-> !ISSUE;
   endproperty
   property p_e1;
      OP_VALID && ar && E1_BUSY |-> !ISSUE;
   endproperty
   property p_dmul;
      take && OP_CLASS == fic_pkg::FIC_OP_MUL && OP_DOUBLE && !vec
         |=> E1_BUSY ##1 !E1_BUSY;
   endproperty
   property p_div_s;
      take && dv && !OP_DOUBLE |=> s_div13 ##1 !DIV_BUSY;
   endproperty
   property p_div_d;
      take && dv && OP_DOUBLE |=> s_div27 ##1 !DIV_BUSY;
   endproperty
   property p_div_hold;
      OP_VALID && dv && DIV_BUSY |-> !ISSUE;
   endproperty
   property p_vec;
      take && ar && !OP_DOUBLE && vec && VECTOR_LENGTH_FIELD == 3'h3
         |=> s_vec4;
   endproperty
   property p_bank0;
      take && ar && !OP_DOUBLE && VECTOR_LENGTH_FIELD != 3'h0
         && OP_DEST < 5'h08 |=> !E1_BUSY;
   endproperty
   property p_lat;
      take && OP_CLASS == fic_pkg::FIC_OP_SIMPLE
         && OP_SRC_DOUBLE != OP_PROD_DOUBLE
         |=> ISSUE_LATENCY == fic_pkg::FIC_LAT_SIMPLE
         && ISSUE_THROUGHPUT == 6'h01;
   endproperty
   property p_hold;
      CORE_HOLD |-> STALL && LS_BUSY;
   endproperty
   a_stall: assert property (p_stall)
      else $error("stall differs from valid and not issued");
   a_ls_core: assert property (p_ls_core)
      else $error("transfer issued during core stall");
   a_ls_busy: assert property (p_ls_busy)
      else $error("transfer issued while multiple runs");
   a_e1: assert property (p_e1)
      else $error("arithmetic issued while first stage held");
   a_dmul: assert property (p_dmul)
      else $error("double multiply first stage not two cycles");
   a_div_s: assert property (p_div_s)
      else $error("single divide busy not 13 cycles");
   a_div_d: assert property (p_div_d)
      else $error("double divide busy not 27 cycles");
   a_div_hold: assert property (p_div_hold)
      else $error("divide issued while divide pipe busy");
   a_vec: assert property (p_vec)
      else $error("vector first stage hold not four cycles");
   a_bank0: assert property (p_bank0)
      else $error("bank zero op not run as scalar");
   a_lat: assert property (p_lat)
      else $error("simple op timing wrong");
   a_hold: assert property (p_hold)
      else $error("core hold without stall behind multiple");
endmodule : fic_issue_control_chk

bind fic_issue_control fic_issue_control_chk chk_u (
   .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
   .OP_VALID(OP_VALID), .OP_CLASS(OP_CLASS), .OP_DOUBLE(OP_DOUBLE),
   .OP_DEST(OP_DEST), .OP_SRC_DOUBLE(OP_SRC_DOUBLE),
   .OP_PROD_DOUBLE(OP_PROD_DOUBLE),
   .VECTOR_LENGTH_FIELD(VECTOR_LENGTH_FIELD),
   .CORE_DATA_STALL(CORE_DATA_STALL), .ISSUE(ISSUE), .STALL(STALL),
   .CORE_HOLD(CORE_HOLD), .ISSUE_LATENCY(ISSUE_LATENCY),
   .ISSUE_THROUGHPUT(ISSUE_THROUGHPUT), .LS_BUSY(LS_BUSY),
   .E1_BUSY(E1_BUSY), .DIV_BUSY(DIV_BUSY));
`default_nettype wire

// [sim/fic_core_model.sv]
// Host core model: presents one candidate and holds it until taken.
// Assumes callers run 1 ns after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module fic_core_model (
   // Clock
   input wire logic clk,
   // Candidate toward the issue block
   output var logic op_valid,
   output var fic_pkg::fic_op_t op_class,
   output var logic op_double,
   output var logic op_multiple,
   output var logic [4:0] op_word_count,
   output var logic [4:0] op_dest,
   output var logic [31:0] op_src_mask,
   output var logic [2:0] vec_len,
   output var logic data_stall,
   // Answer
   input wire logic issue
);
   initial begin
      op_valid = 1'b0;
      op_class = fic_pkg::FIC_OP_NONE;
      op_double = 1'b0;
      op_multiple = 1'b0;
      op_word_count = 5'h00;
      op_dest = 5'h00;
      op_src_mask = 32'h00000000;
      vec_len = 3'h0;
      data_stall = 1'b0;
   end
   task automatic send(input fic_pkg::fic_op_t c, input logic d, m,
         input logic [4:0] n, dst, input int s, input logic [2:0] ln,
         output int w);
      logic got;
      got = 1'b0;
      w = 0;
      op_class = c;
      op_double = d;
      op_multiple = m;
      op_word_count = n;
      op_dest = dst;
      op_src_mask = 32'h00000001 << s;
      vec_len = ln;
      op_valid = 1'b1;
      while (!got && w < 40) begin
         #7;
         if (issue === 1'b1) got = 1'b1;
         else w++;
         @(posedge clk);
         #1;
      end
   endtask : send
   task automatic stall_for(input int n);
      data_stall = 1'b1;
      repeat (n) @(posedge clk);
      #1;
      data_stall = 1'b0;
   endtask : stall_for
   task automatic idle(input int n);
      op_valid = 1'b0;
      repeat (n) @(posedge clk);
      #1;
   endtask : idle
endmodule : fic_core_model
`default_nettype wire

// [sim/fic_issue_control_tb.sv]
// Testbench for the issue control block, driven through the core model.
// Assumes a 100 MHz clock and the bound checker.
`timescale 1ns/10ps
`default_nettype none
module fic_issue_control_tb;
   logic sys_clk, reset_n, op_valid, op_double, op_multiple, data_stall;
   fic_pkg::fic_op_t op_class;
   logic [4:0] op_word_count, op_dest;
   logic [31:0] op_src_mask;
   logic [2:0] vec_len;
   logic issue, stall, hold, ls_busy, e1_busy, div_busy;
   logic [5:0] lat, thr;
   logic clk_en, src_dbl, prod_dbl;
   int err_total, compares, w;
   fic_core_model core_u (.clk(sys_clk), .op_valid(op_valid),
      .op_class(op_class), .op_double(op_double),
      .op_multiple(op_multiple), .op_word_count(op_word_count),
      .op_dest(op_dest), .op_src_mask(op_src_mask), .vec_len(vec_len),
      .data_stall(data_stall), .issue(issue));
   fic_issue_control dut_u (.SYS_CLK(sys_clk), .RESET_N(reset_n),
      .CLK_EN(clk_en), .OP_VALID(op_valid), .OP_CLASS(op_class),
      .OP_DOUBLE(op_double), .OP_MULTIPLE(op_multiple),
      .OP_WORD_COUNT(op_word_count), .OP_DEST(op_dest),
      .OP_SRC_MASK(op_src_mask), .OP_SRC_DOUBLE(src_dbl),
      .OP_PROD_DOUBLE(prod_dbl), .VECTOR_LENGTH_FIELD(vec_len),
      .CORE_DATA_STALL(data_stall), .ISSUE(issue), .STALL(stall),
      .CORE_HOLD(hold), .ISSUE_LATENCY(lat), .ISSUE_THROUGHPUT(thr),
      .LS_BUSY(ls_busy), .E1_BUSY(e1_busy), .DIV_BUSY(div_busy));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic print_verdict();
      $display("compares %0d errors %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   task automatic chk_w(input int got, input int exp);
      compares++;
      if (got >= 40) begin
         err_total++;
         $display("[FAIL] %0t wait bound used up", $time);
         print_verdict();
      end else if (got != exp) begin
         err_total++;
         $display("[FAIL] %0t stalls %0d exp %0d", $time, got, exp);
      end
   endtask : chk_w
   task automatic chk_v(input logic [5:0] got, input logic [5:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t value %0h exp %0h", $time, got, exp);
      end
   endtask : chk_v
   task automatic t_arith();
      core_u.send(fic_pkg::FIC_OP_SIMPLE, 0, 0, 1, 5'h08, 1, 0, w);
      chk_w(w, 0);
      chk_v(lat, fic_pkg::FIC_LAT_SIMPLE);
      chk_v(thr, 6'h01);
      core_u.send(fic_pkg::FIC_OP_MUL, 1, 0, 1, 5'h0A, 2, 0, w);
      chk_w(w, 0);
      chk_v(lat, fic_pkg::FIC_LAT_MUL_D);
      chk_v(thr, fic_pkg::FIC_THR_MUL_D);
      chk_v(6'(e1_busy), 6'h01);
      core_u.send(fic_pkg::FIC_OP_MUL, 0, 0, 1, 5'h0E, 4, 0, w);
      chk_w(w, 1);
      chk_v(lat, fic_pkg::FIC_LAT_MUL_S);
      core_u.idle(6);
   endtask : t_arith
   task automatic t_div(input logic d);
      core_u.send(fic_pkg::FIC_OP_DIVSQRT, d, 0, 1, 5'h00, 1, 0, w);
      chk_w(w, 0);
      chk_v(lat, d ? fic_pkg::FIC_LAT_DIV_D : fic_pkg::FIC_LAT_DIV_S);
      chk_v(thr, d ? fic_pkg::FIC_THR_DIV_D : fic_pkg::FIC_THR_DIV_S);
      chk_v(6'(div_busy), 6'h01);
      core_u.send(fic_pkg::FIC_OP_SIMPLE, 0, 0, 1, 5'h0A, 20, 0, w);
      chk_w(w, 0);
      core_u.send(fic_pkg::FIC_OP_DIVSQRT, d, 0, 1, 5'h04, 6, 0, w);
      chk_w(w, int'(d ? fic_pkg::FIC_THR_DIV_D
         : fic_pkg::FIC_THR_DIV_S) - 2);
      core_u.idle(32);
   endtask : t_div
   task automatic t_ls();
      fork
         core_u.stall_for(5);
         core_u.send(fic_pkg::FIC_OP_LOAD, 0, 0, 1, 5'h1C, 31, 0, w);
      join
      chk_w(w, 5);
      core_u.send(fic_pkg::FIC_OP_LOAD, 0, 1, 5'h05, 5'h08, 30, 0, w);
      chk_w(w, 0);
      chk_v(lat, fic_pkg::FIC_LAT_LOAD_EXTRA + 6'h03);
      chk_v(6'(ls_busy), 6'h01);
      core_u.send(fic_pkg::FIC_OP_LOAD, 0, 0, 1, 5'h10, 31, 0, w);
      chk_w(w, 2);
      core_u.idle(6);
   endtask : t_ls
   task automatic t_vec();
      core_u.send(fic_pkg::FIC_OP_SIMPLE, 0, 0, 1, 5'h10, 24, 3'h3, w);
      chk_w(w, 0);
      core_u.send(fic_pkg::FIC_OP_LOAD, 0, 0, 1, 5'h1C, 31, 0, w);
      chk_w(w, 0);
      core_u.send(fic_pkg::FIC_OP_SIMPLE, 0, 0, 1, 5'h08, 2, 0, w);
      chk_w(w, 2);
      core_u.idle(6);
      core_u.send(fic_pkg::FIC_OP_SIMPLE, 0, 0, 1, 5'h02, 3, 3'h3, w);
      chk_w(w, 0);
      core_u.send(fic_pkg::FIC_OP_SIMPLE, 0, 0, 1, 5'h05, 6, 0, w);
      chk_w(w, 0);
      core_u.idle(6);
   endtask : t_vec
   task automatic t_frz();
      prod_dbl = 1'b0;
      core_u.send(fic_pkg::FIC_OP_DIVSQRT, 0, 0, 1, 5'h00, 1, 0, w);
      chk_w(w, 0);
      chk_v(lat, fic_pkg::FIC_LAT_DIV_S - fic_pkg::FIC_FWD_SAVE);
      clk_en = 1'b0;
      prod_dbl = 1'b1;
      core_u.idle(5);
      chk_v(6'(div_busy), 6'h01);
      clk_en = 1'b1;
      core_u.send(fic_pkg::FIC_OP_SYSREG, 0, 0, 1, 5'h18, 25, 0, w);
      chk_w(w, int'(fic_pkg::FIC_DIV_BUSY_S));
      chk_v(lat, fic_pkg::FIC_LAT_SYSREG);
      core_u.idle(4);
   endtask : t_frz
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      src_dbl = 1'b0;
      prod_dbl = 1'b1;
      err_total = 0;
      compares = 0;
      repeat (6) @(posedge sys_clk);
      #1;
      reset_n = 1'b1;
      @(posedge sys_clk);
      #1;
      t_arith();
      t_div(1'b0);
      t_div(1'b1);
      t_ls();
      t_vec();
      t_frz();
      print_verdict();
   end
endmodule : fic_issue_control_tb
`default_nettype wire
